// >>> shared/symbol_port_pkg.sv
// Purpose: Constants for the 100M symbol-mode MAC port of the PHY.
// Assumes: Core clock at 125 MHz; symbol clocks at 25 MHz derived from it.
// Notes:   How it works list below; tags in the design mark where each point lives.
//
// How it works
// - Drive the receive symbol clock at 25 MHz while symbol mode is selected.
// - Receive code group bit 0 is the LSB, bit 4 the MSB.
// - Every recovered code group, idles included, goes out unframed each symbol period.
// - Receive data valid is never asserted in symbol mode.
// - Receive symbol lines change on the rising receive symbol clock edge.
// - All five transmit lines are sampled every rising transmit clock edge.
// - Transmit enable is ignored; sampling never depends on it.
// - Float request high releases the receive-side outputs.
// - PHY address 00 floats the receive-side outputs as well.
// - The collision output has no function in symbol mode.
// - The fifth receive bit goes out on the receive-error pin.
// - The device sources the transmit symbol clock.
// - The transmit symbol clock runs at 25 MHz.

package symbol_port_pkg;

    // =========================================================================
    // Code groups
    localparam int          SYM_W         = 5;
    localparam logic [4:0]  IDLE_SYM      = 5'h1f;
    localparam int          SYM_MSB_POS   = 4;

    // =========================================================================
    // Clocking
    localparam int          REF_CLK_KHZ   = 125000;
    localparam int          SYM_CLK_KHZ   = 25000;
    localparam int          SYM_DIV       = REF_CLK_KHZ / SYM_CLK_KHZ;
    localparam int          SYM_HIGH      = (SYM_DIV + 1) / 2;
    localparam logic [2:0]  DIV_LAST      = 3'(SYM_DIV - 1);
    localparam logic [2:0]  DIV_HIGH      = 3'(SYM_HIGH);

    // =========================================================================
    // Receive crossing ring
    localparam int          PTR_W         = 3;
    localparam int          RING_DEPTH    = 4;
    localparam logic [2:0]  PTR_RST       = 3'h0;

    // =========================================================================
    // Reset values
    localparam logic [4:0]  PHY_ADDR_RST  = 5'h00;
    localparam logic [4:0]  FLOAT_ADDR    = 5'h00;

endpackage

// >>> src/phy_symbol_mode_mac_port.sv
// Purpose: MAC-side symbol port of the PHY in 100M symbol mode.
// Assumes: LINE_CLK is the recovered line clock; REF_CLK is the local 125 MHz clock.
// Notes:   Both symbol clocks are divided from REF_CLK and driven out as flops.
//          Transmit pins are resynchronised, so a group reaches the line side
//          at the first symbol tick at least three core cycles after the MAC presents it.

`timescale 1ns/1ps
`default_nettype none

module phy_symbol_mode_mac_port
    import symbol_port_pkg::*;
(
    // Core clock and reset
    input  wire logic             REF_CLK,
    input  wire logic             RST,
    // Recovered line side
    input  wire logic             LINE_CLK,
    input  wire logic [SYM_W-1:0] LINE_RX_SYM,
    input  wire logic             LINE_RX_VALID,
    output logic      [SYM_W-1:0] LINE_TX_SYM,
    output logic                  LINE_TX_STROBE,
    // Mode and straps
    input  wire logic             SYMBOL_MODE,
    input  wire logic [4:0]       PHY_ADDR,
    input  wire logic             RX_FLOAT_REQ,
    // Receive pins toward the MAC
    output logic                  RX_SYM_CLK,
    output logic                  RX_SYM_CLK_OE,
    output logic      [3:0]       RX_SYM_D,
    output logic                  RX_SYM_D4,
    output logic                  RX_SYM_OE,
    output logic                  SYMBOL_CARRIER,
    output logic                  RX_DATA_VALID,
    output logic                  COL,
    // Transmit clock to the MAC and transmit pins from the MAC
    output logic                  TX_SYM_CLK,
    input  wire logic [3:0]       TX_SYM_D,
    input  wire logic             TX_SYM_D4
);

    function automatic logic [PTR_W-1:0] to_gray(input logic [PTR_W-1:0] b);
        to_gray = b ^ (b >> 1);
    endfunction

    // Both pointers step the same way, so one increment keeps them in agreement.
    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = p + 3'h1;
    endfunction

    // Both symbol clocks share one waveform, so one decode keeps them in phase.
    function automatic logic clk_level(input logic [2:0] cnt, input logic mode);
        clk_level = mode && (cnt < DIV_HIGH);
    endfunction

    // Float request and the all-zero address release the pins the same way.
    function automatic logic drive_ok(input logic flt, input logic [4:0] addr);
        drive_ok = !(flt || (addr == FLOAT_ADDR));
    endfunction

    function automatic logic [PTR_W-1:0] from_gray(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b = g;
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        from_gray = b;
    endfunction

    // =========================================================================
    // Line-domain reset
    // RST belongs to REF_CLK, so it is resynchronised before the line side uses it.
    // The line side therefore leaves reset a few line clocks after the core does.
    logic line_rst_m_q;
    logic line_rst_q;

    always_ff @(posedge LINE_CLK) begin
        line_rst_m_q <= RST;
        line_rst_q   <= line_rst_m_q;
    end

    // =========================================================================
    // Receive crossing ring, write side
    // Four entries absorb the phase wander between the line and core clocks.
    logic [SYM_W-1:0] ring_mem [RING_DEPTH];
    logic [PTR_W-1:0] wr_bin_q;
    logic [PTR_W-1:0] wr_gray_q;
    logic [PTR_W-1:0] rd_gray_q;
    logic [PTR_W-1:0] rd_gray_m_q;
    logic [PTR_W-1:0] rd_gray_s_q;
    logic [PTR_W-1:0] wr_bin_d;
    logic             ring_full;
    logic             ring_push;

    assign ring_full = (wr_gray_q == {~rd_gray_s_q[PTR_W-1:PTR_W-2], rd_gray_s_q[PTR_W-3:0]});
    assign ring_push = LINE_RX_VALID && !ring_full;
    assign wr_bin_d  = ptr_inc(wr_bin_q);

    always_ff @(posedge LINE_CLK) begin
        rd_gray_m_q <= rd_gray_q;
        rd_gray_s_q <= rd_gray_m_q;
    end

    always_ff @(posedge LINE_CLK) begin
        if (ring_push) begin
            ring_mem[wr_bin_q[PTR_W-2:0]] <= LINE_RX_SYM;
        end
    end

    always_ff @(posedge LINE_CLK) begin
        if (line_rst_q) begin
            wr_bin_q <= PTR_RST;
        end else if (ring_push) begin
            wr_bin_q <= wr_bin_d;
        end
    end

    always_ff @(posedge LINE_CLK) begin
        if (line_rst_q) begin
            wr_gray_q <= PTR_RST;
        end else if (ring_push) begin
            wr_gray_q <= to_gray(wr_bin_d);
        end
    end

    // =========================================================================
    // Pin synchronisers
    logic       mode_m_q;
    logic       mode_s_q;
    logic       float_m_q;
    logic       float_s_q;
    logic [4:0] addr_m_q;
    logic [4:0] addr_s_q;
    logic [3:0] txd_m_q;
    logic [3:0] txd_s_q;
    logic       txd4_m_q;
    logic       txd4_s_q;

    always_ff @(posedge REF_CLK) begin
        mode_m_q <= SYMBOL_MODE;
        mode_s_q <= mode_m_q;
    end

    always_ff @(posedge REF_CLK) begin
        float_m_q <= RX_FLOAT_REQ;
        float_s_q <= float_m_q;
    end

    // The strap is static, so a bus-wide pair of stages is safe here.
    always_ff @(posedge REF_CLK) begin
        addr_m_q <= PHY_ADDR;
        addr_s_q <= addr_m_q;
    end

    // The MAC holds each group for a full symbol period, so the bits settle together.
    always_ff @(posedge REF_CLK) begin
        txd_m_q <= TX_SYM_D;
        txd_s_q <= txd_m_q;
    end

    always_ff @(posedge REF_CLK) begin
        txd4_m_q <= TX_SYM_D4;
        txd4_s_q <= txd4_m_q;
    end

    // =========================================================================
    // Address strap
    // The strap is taken two cycles after release so the synchroniser has settled.
    // A later change of the strap pins is ignored until the next reset.
    logic [1:0] strap_wait_q;
    logic [4:0] phy_addr_q;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            strap_wait_q <= 2'h0;
        end else if (strap_wait_q != 2'h3) begin
            strap_wait_q <= strap_wait_q + 2'h1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            phy_addr_q <= PHY_ADDR_RST;
        end else if (strap_wait_q == 2'h2) begin
            phy_addr_q <= addr_s_q;
        end
    end

    // =========================================================================
    // Symbol clock divider
    // The counter runs 0 to 4; both clocks are high for the counts 0 to 2.
    logic [2:0] div_cnt_q;
    logic [2:0] div_cnt_d;
    logic       sym_tick;

    assign sym_tick  = (div_cnt_q == DIV_LAST);
    assign div_cnt_d = sym_tick ? 3'h0 : div_cnt_q + 3'h1;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            // Starting at the last count makes the first high phase full length.
            div_cnt_q <= DIV_LAST;
        end else begin
            div_cnt_q <= div_cnt_d;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            RX_SYM_CLK <= 1'b0;
        end else begin
            RX_SYM_CLK <= clk_level(div_cnt_d, mode_s_q);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            TX_SYM_CLK <= 1'b0;
        end else begin
            TX_SYM_CLK <= clk_level(div_cnt_d, mode_s_q);
        end
    end

    // =========================================================================
    // Receive crossing ring, read side
    // A full ring drops the newest group, so the line must average no more
    // than one group per symbol period.
    logic [PTR_W-1:0] rd_bin_q;
    logic [PTR_W-1:0] wr_gray_m_q;
    logic [PTR_W-1:0] wr_gray_s_q;
    logic [PTR_W-1:0] rd_bin_d;
    logic             ring_empty;
    logic             ring_pop;

    assign ring_empty = (rd_gray_q == wr_gray_s_q);
    assign ring_pop   = sym_tick && !ring_empty;
    assign rd_bin_d   = ptr_inc(rd_bin_q);

    always_ff @(posedge REF_CLK) begin
        wr_gray_m_q <= wr_gray_q;
        wr_gray_s_q <= wr_gray_m_q;
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            rd_bin_q <= PTR_RST;
        end else if (ring_pop) begin
            rd_bin_q <= rd_bin_d;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            rd_gray_q <= PTR_RST;
        end else if (ring_pop) begin
            rd_gray_q <= to_gray(rd_bin_d);
        end
    end

    // =========================================================================
    // Receive symbol output
    // An empty ring yields idle rather than a stall, so the stream never pauses.
    logic [SYM_W-1:0] rx_sym_next;

    assign rx_sym_next = ring_empty ? IDLE_SYM : ring_mem[rd_bin_q[PTR_W-2:0]];

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            RX_SYM_D  <= IDLE_SYM[3:0];
            RX_SYM_D4 <= IDLE_SYM[SYM_MSB_POS];
        end else if (sym_tick) begin
            RX_SYM_D  <= rx_sym_next[3:0];
            RX_SYM_D4 <= rx_sym_next[SYM_MSB_POS];
        end
    end

    // The carrier follows the group it qualifies, so both change on one edge.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            SYMBOL_CARRIER <= 1'b0;
        end else if (sym_tick) begin
            SYMBOL_CARRIER <= (rx_sym_next != IDLE_SYM);
        end
    end

    always_ff @(posedge REF_CLK) begin
        RX_DATA_VALID <= 1'b0;
    end

    always_ff @(posedge REF_CLK) begin
        COL <= 1'b0;
    end

    // =========================================================================
    // Receive-side release
    // Float conditions
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            RX_SYM_OE <= 1'b0;
        end else begin
            RX_SYM_OE <= drive_ok(float_s_q, phy_addr_q);
        end
    end

    // The receive clock is released with the data so a shared bus has one driver.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            RX_SYM_CLK_OE <= 1'b0;
        end else begin
            RX_SYM_CLK_OE <= drive_ok(float_s_q, phy_addr_q);
        end
    end

    // =========================================================================
    // Transmit sampling
    // The MAC changes data after our rising edge; the synchronised copy is stable
    // for the rest of the symbol period, so it is taken at the next rising edge.
    // Sample every edge
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            LINE_TX_STROBE <= 1'b0;
        end else begin
            LINE_TX_STROBE <= sym_tick && mode_s_q;
        end
    end

    // Nothing is sampled outside symbol mode, so a stale group never reaches the line.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            LINE_TX_SYM <= IDLE_SYM;
        end else if (sym_tick && mode_s_q) begin
            LINE_TX_SYM <= {txd4_s_q, txd_s_q};
        end
    end

endmodule

`default_nettype wire

// >>> sim/symbol_port_assertions.sv
// Purpose: Port assertions for the symbol-mode MAC port.
// Assumes: SYMBOL_MODE stays high while the clocks are checked.
// Notes:   Bound to the design after the module.
`timescale 1ns/1ps
`default_nettype none
module symbol_port_checker
    import symbol_port_pkg::*;
(
    // Clock, reset and straps
    input wire logic       REF_CLK,
    input wire logic       RST,
    input wire logic       SYMBOL_MODE,
    input wire logic [4:0] PHY_ADDR,
    input wire logic       RX_FLOAT_REQ,
    // Receive pins
    input wire logic       RX_SYM_CLK,
    input wire logic       RX_SYM_CLK_OE,
    input wire logic [3:0] RX_SYM_D,
    input wire logic       RX_SYM_D4,
    input wire logic       RX_SYM_OE,
    input wire logic       RX_DATA_VALID,
    input wire logic       COL,
    // Transmit pins and line side
    input wire logic       TX_SYM_CLK,
    input wire logic [3:0] TX_SYM_D,
    input wire logic       TX_SYM_D4,
    input wire logic [4:0] LINE_TX_SYM,
    input wire logic       LINE_TX_STROBE
);
    logic [3:0] up_q;
    // =====================================================================
    // Cycles since reset release, so strap and sync delays have settled.
    always_ff @(posedge REF_CLK) begin
        if (RST)
            up_q <= 4'h0;
        else if (up_q != 4'hf)
            up_q <= up_q + 4'h1;
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    a_rxdv_never: assert property (!RX_DATA_VALID)
        else $error("rx valid raised");
    a_col_unused: assert property (!COL)
        else $error("collision raised");
    a_rxclk_rate: assert property ($rose(RX_SYM_CLK) && SYMBOL_MODE |->
        RX_SYM_CLK [*3] ##1 !RX_SYM_CLK [*2] ##1 RX_SYM_CLK) else $error("rx clock rate");
    a_txclk_rate: assert property ($rose(TX_SYM_CLK) && SYMBOL_MODE |->
        TX_SYM_CLK [*3] ##1 !TX_SYM_CLK [*2] ##1 TX_SYM_CLK) else $error("tx clock rate");
    a_rx_edge_only: assert property (!$rose(RX_SYM_CLK) |->
        $stable({RX_SYM_D4, RX_SYM_D})) else $error("rx data off edge");
    a_float_release: assert property ($rose(RX_FLOAT_REQ) |->
        ##[1:4] (!RX_SYM_OE && !RX_SYM_CLK_OE)) else $error("float not released");
    a_float_holds: assert property (up_q > 4'h4 && RX_FLOAT_REQ &&
        $past(RX_FLOAT_REQ, 4) |-> !RX_SYM_OE) else $error("driving while float");
    a_addr_floats: assert property (up_q > 4'h6 && PHY_ADDR == FLOAT_ADDR |->
        !RX_SYM_OE && !RX_SYM_CLK_OE) else $error("driving at address 0");
    a_tx_every_edge: assert property (LINE_TX_STROBE == $rose(TX_SYM_CLK))
        else $error("tx sample not on clock rise");
    a_tx_bit_order: assert property (LINE_TX_STROBE |->
        LINE_TX_SYM == $past({TX_SYM_D4, TX_SYM_D}, 3)) else $error("tx group wrong");
endmodule
bind phy_symbol_mode_mac_port symbol_port_checker u_chk (.REF_CLK, .RST, .SYMBOL_MODE,
    .PHY_ADDR, .RX_FLOAT_REQ, .RX_SYM_CLK, .RX_SYM_CLK_OE, .RX_SYM_D, .RX_SYM_D4,
    .RX_SYM_OE, .RX_DATA_VALID, .COL, .TX_SYM_CLK, .TX_SYM_D, .TX_SYM_D4,
    .LINE_TX_SYM, .LINE_TX_STROBE);
`default_nettype wire

// >>> sim/mac_model.sv
// Purpose: MAC side of the symbol port, sending code groups.
// Assumes: The symbol clock is sampled on the core clock.
// Notes:   Changes data one cycle after each clock rise.
`timescale 1ns/1ps
`default_nettype none
module mac_model
    import symbol_port_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       sym_clk,
    // Transmit lines
    output logic      [3:0] tx_d,
    output logic            tx_d4,
    output logic      [4:0] sent
);
    logic       clk_q;
    logic [4:0] cnt_q;
    always_ff @(posedge ref_clk) begin
        clk_q <= sym_clk;
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_q <= 5'h00;
            sent  <= IDLE_SYM;
        end else if (sym_clk && !clk_q) begin
            cnt_q <= cnt_q + 5'h01;
            sent  <= (cnt_q[1:0] == 2'h3) ? IDLE_SYM : cnt_q ^ 5'h15;
        end
    end
    assign tx_d  = sent[3:0];
    assign tx_d4 = sent[4];
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Purpose: Self-checking bench for the symbol-mode MAC port.
// Assumes: Line pushes stay below the symbol rate.
// Notes:   Monitors judge each non-idle receive group, and each transmit group while tx_on is set.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import symbol_port_pkg::*;
;
    logic       ref_clk, line_clk, rst, vld, mode, flt, rclk, rclk_oe, roe, rclk_q;
    logic       rxd4, txd4, carr, rdv, col, tclk, tstb, tx_on;
    logic [3:0] rxd, txd;
    logic [4:0] lsym, addr, lts, sent;
    logic [4:0] exp_q[$];
    int         failures, comparisons, cyc, rx_seen, tx_seen;
    phy_symbol_mode_mac_port u_dut (.REF_CLK(ref_clk), .RST(rst), .LINE_CLK(line_clk),
        .LINE_RX_SYM(lsym), .LINE_RX_VALID(vld), .LINE_TX_SYM(lts), .LINE_TX_STROBE(tstb),
        .SYMBOL_MODE(mode), .PHY_ADDR(addr), .RX_FLOAT_REQ(flt), .RX_SYM_CLK(rclk),
        .RX_SYM_CLK_OE(rclk_oe), .RX_SYM_D(rxd), .RX_SYM_D4(rxd4), .RX_SYM_OE(roe),
        .SYMBOL_CARRIER(carr), .RX_DATA_VALID(rdv), .COL(col), .TX_SYM_CLK(tclk),
        .TX_SYM_D(txd), .TX_SYM_D4(txd4));
    mac_model u_mac (.ref_clk(ref_clk), .rst(rst), .sym_clk(tclk), .tx_d(txd),
        .tx_d4(txd4), .sent(sent));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        line_clk = 1'b0;
        #3;
        forever #7.5 line_clk = ~line_clk;
    end
    task automatic check(input string what, input logic [4:0] seen, input logic [4:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // =====================================================================
    // Monitors: receive groups at each clock rise, transmit groups at strobe.
    always @(posedge ref_clk) begin
        rclk_q <= rclk;
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_sim;
        end
        if (rclk && !rclk_q && roe) begin
            check("carrier", {4'h0, carr}, {4'h0, ({rxd4, rxd} != IDLE_SYM)});
        end
        if (rclk && !rclk_q && roe && {rxd4, rxd} !== IDLE_SYM) begin
            check("rx group", {rxd4, rxd}, exp_q.size() ? exp_q.pop_front() : IDLE_SYM);
            rx_seen++;
        end
        if (tstb && tx_on) begin
            check("tx group", lts, sent);
            tx_seen++;
        end
    end
    task automatic do_reset(input logic [4:0] a);
        @(posedge ref_clk);
        rst  <= 1'b1;
        addr <= a;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (12) @(posedge ref_clk);
        #1;
    endtask
    task automatic t_rx;
        int base;
        base = rx_seen;
        for (int i = 0; i < 31; i++) begin
            @(posedge line_clk);
            lsym <= 5'(i);
            vld  <= 1'b1;
            exp_q.push_back(5'(i));
            @(posedge line_clk);
            vld <= 1'b0;
            @(posedge line_clk);
        end
        repeat (40) @(posedge ref_clk);
        check("rx count", 5'(rx_seen - base), 5'h1f);
    endtask
    task automatic t_tx;
        @(posedge ref_clk);
        #1 tx_on = 1'b1;
        repeat (100) @(posedge ref_clk);
        #1 tx_on = 1'b0;
        check("tx count", 5'(tx_seen), 5'h14);
    endtask
    task automatic t_float;
        @(posedge ref_clk);
        flt <= 1'b1;
        repeat (5) @(posedge ref_clk);
        #1 check("float oe", {3'h0, roe, rclk_oe}, 5'h00);
        @(posedge ref_clk);
        flt <= 1'b0;
        repeat (8) @(posedge ref_clk);
        #1 check("drive oe", {3'h0, roe, rclk_oe}, 5'h03);
    endtask
    task automatic t_addr;
        do_reset(FLOAT_ADDR);
        check("addr 0 oe", {3'h0, roe, rclk_oe}, 5'h00);
        do_reset(5'h01);
        check("addr 1 oe", {3'h0, roe, rclk_oe}, 5'h03);
    endtask
    initial begin
        rst   = 1'b1;
        vld   = 1'b0;
        lsym  = 5'h00;
        mode  = 1'b1;
        addr  = 5'h01;
        flt   = 1'b0;
        tx_on = 1'b0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (12) @(posedge ref_clk);
        t_rx;
        t_tx;
        t_float;
        t_addr;
        t_rx;
        end_sim;
    end
endmodule
`default_nettype wire
